// file: design/pke_defs.svh
`ifndef PKE_DEFS_SVH
`define PKE_DEFS_SVH

// Register byte offsets on the plain register port
`define PKE_OFS_CONTROL      8'h00
`define PKE_OFS_STATUS       8'h04
`define PKE_OFS_COMMAND      8'h08

// Launch control register layout
`define PKE_CTL_LAUNCH       0

// Result status register layout
`define PKE_ST_BUSY          16
`define PKE_ST_PRIME         12
`define PKE_ST_NOINV         11
`define PKE_ST_COEFF         10
`define PKE_ST_SIGREJ        9
`define PKE_ST_ORDER         7
`define PKE_ST_COORD         6
`define PKE_ST_INFTY         5
`define PKE_ST_OFFCRV        4
`define PKE_ST_FAIL_MSB      3
`define PKE_ST_FAIL_LSB      0

// Reset values and writable masks
`define PKE_CONTROL_RST      32'h0000_0000
`define PKE_STATUS_RST       32'h0000_0000
`define PKE_COMMAND_RST      32'h0000_0000
`define PKE_COMMAND_MASK     32'he000_ffff

// Operation group codes, opcode bits 6:4
`define PKE_GRP_PRIM         3'h0
`define PKE_GRP_RSA          3'h1
`define PKE_GRP_ECC          3'h2
`define PKE_GRP_ECDSA        3'h3

// Low nibble codes, opcode bits 3:0
`define PKE_LO_INV_ODD       4'h6
`define PKE_LO_INV_EVEN      4'h9
`define PKE_LO_CHK_AB        4'h3
`define PKE_LO_CHK_N         4'h4
`define PKE_LO_CHK_CPL       4'h5
`define PKE_LO_CHK_POC       4'h6
`define PKE_LO_ED_CHKVALID   4'hb
`define PKE_LO_ED_POC        4'hc
`define PKE_LO_DSA_GEN       4'h9
`define PKE_LO_DSA_VER       4'ha
`define PKE_LO_ECDSA_GEN     4'h0
`define PKE_LO_ECDSA_VER     4'h1

`endif

// file: design/pke_pkg.sv
package pke_pkg;

  // Front end sequencing states
  typedef enum logic {
    pke_idle,
    pke_run
  } pke_state_e;

  typedef logic [6:0] pke_opcode_t;
  typedef logic [3:0] pke_fail_t;

endpackage

// file: design/pke_op_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "pke_defs.svh"

module pke_op_decode (
  input  wire pke_pkg::pke_opcode_t op,
  output logic                      upd_noinv,
  output logic                      upd_coeff,
  output logic                      upd_sig,
  output logic                      upd_order,
  output logic                      upd_coord,
  output logic                      upd_infty,
  output logic                      upd_offcrv
);

  // Match a group and a low nibble in one place
  function automatic logic op_is(input logic [6:0] o,
                                 input logic [2:0] g,
                                 input logic [3:0] l);
    op_is = (o[6:4] == g) && (o[3:0] == l);
  endfunction

  wire logic grp_ecc;
  wire logic grp_ecdsa;

  assign grp_ecc   = (op[6:4] == `PKE_GRP_ECC);
  assign grp_ecdsa = (op[6:4] == `PKE_GRP_ECDSA);

  // Which result flags each command is allowed to rewrite
  assign upd_noinv  = op_is(op, `PKE_GRP_PRIM, `PKE_LO_INV_ODD)
                    | op_is(op, `PKE_GRP_PRIM, `PKE_LO_INV_EVEN); // [R8] [R18]
  assign upd_coeff  = op_is(op, `PKE_GRP_ECC, `PKE_LO_CHK_AB); // [R9] [R19]
  assign upd_order  = op_is(op, `PKE_GRP_ECC, `PKE_LO_CHK_N); // [R11] [R19]
  assign upd_coord  = op_is(op, `PKE_GRP_ECC, `PKE_LO_CHK_CPL); // [R12] [R19]
  // Ed25519 on-curve check also reports through the off-curve flag
  assign upd_offcrv = op_is(op, `PKE_GRP_ECC, `PKE_LO_CHK_POC)
                    | op_is(op, `PKE_GRP_ECC, `PKE_LO_ED_POC); // [R14] [R19]
  assign upd_sig    = op_is(op, `PKE_GRP_ECDSA, `PKE_LO_ECDSA_GEN)
                    | op_is(op, `PKE_GRP_ECDSA, `PKE_LO_ECDSA_VER)
                    | op_is(op, `PKE_GRP_RSA, `PKE_LO_DSA_GEN)
                    | op_is(op, `PKE_GRP_RSA, `PKE_LO_DSA_VER)
                    | op_is(op, `PKE_GRP_ECC, `PKE_LO_ED_CHKVALID); // [R10]
  // Every curve operation rewrites the infinity flag
  assign upd_infty  = grp_ecc | grp_ecdsa; // [R13]

endmodule // pke_op_decode

`default_nettype wire

// file: design/pke_result_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "pke_defs.svh"

module pke_result_flags (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                done,
  input  wire logic                upd_prime,
  input  wire logic                upd_noinv,
  input  wire logic                upd_coeff,
  input  wire logic                upd_sig,
  input  wire logic                upd_order,
  input  wire logic                upd_coord,
  input  wire logic                upd_infty,
  input  wire logic                upd_offcrv,
  input  wire logic                res_composite,
  input  wire logic                res_no_inverse,
  input  wire logic                res_coeff_bad,
  input  wire logic                res_sig_reject,
  input  wire logic                res_order_bad,
  input  wire logic                res_coord_bad,
  input  wire logic                res_infinity,
  input  wire logic                res_off_curve,
  input  wire pke_pkg::pke_fail_t  res_fail_addr,
  input  wire logic                sw_wr,
  input  wire logic [7:0]          sw_wdata,
  output logic [15:0]              flags
);

  logic              prime_r;
  logic              noinv_r;
  logic              coeff_r;
  logic              sig_r;
  logic [7:0]        low_r;
  logic [7:0]        low_sw;
  logic [7:0]        low_nxt;
  wire  logic        fail_hit;

  // The engine moves the fail location only when a point really failed
  assign fail_hit = (upd_offcrv & res_off_curve)
                  | (upd_coord & res_coord_bad)
                  | (upd_infty & res_infinity); // [R15]

  // Software write first, then the engine's update on top of it
  always_comb begin
    low_sw  = sw_wr ? sw_wdata : low_r;
    low_nxt = low_sw;
    if (done && upd_order) low_nxt[`PKE_ST_ORDER] = res_order_bad; // [R11]
    if (done && upd_coord) low_nxt[`PKE_ST_COORD] = res_coord_bad; // [R12]
    if (done && upd_infty) low_nxt[`PKE_ST_INFTY] = res_infinity; // [R13]
    if (done && upd_offcrv) begin
      low_nxt[`PKE_ST_OFFCRV] = res_off_curve; // [R14]
    end
    if (done && fail_hit) begin
      low_nxt[`PKE_ST_FAIL_MSB:`PKE_ST_FAIL_LSB] = res_fail_addr; // [R15]
    end
  end

  // Flags hold until a command that owns them completes; bits 7:0 also take software status writes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prime_r <= 1'b0; // [R21]
      noinv_r <= 1'b0;
      coeff_r <= 1'b0;
      sig_r   <= 1'b0;
      low_r   <= 8'h00;
    end else begin
      if (done && upd_prime) prime_r <= res_composite; // [R7]
      if (done && upd_noinv) noinv_r <= res_no_inverse; // [R8]
      if (done && upd_coeff) coeff_r <= res_coeff_bad; // [R9]
      if (done && upd_sig)   sig_r   <= res_sig_reject; // [R10]
      low_r <= low_nxt; // [R21]
    end
  end

  // Bits 15:13 and 8 stay zero
  assign flags = {3'h0, prime_r, noinv_r, coeff_r, sig_r, 1'b0, low_r};

endmodule // pke_result_flags

`default_nettype wire

// file: design/pke_launch_ctrl.sv
// Contract
// R1: Software launches only after all operands sit in shared memory.
// R2: Launch bit is control bit 0, active high, sampled on rising edge.
// R3: Launch starts the operation held in the command register.
// R4: Launch while busy is ignored; nothing restarts or queues.
// R5: Hardware clears the launch bit when the operation completes.
// R6: Status bit 16 busy is high while processing, low when finished.
// R7: Status bit 12 after primality test: 0 probably prime, 1 composite.
// R8: Status bit 11 set when inversion (nibble 6 or 9) has no inverse.
// R9: Status bit 10 set after AB check when curve coefficients invalid.
// R10: Status bit 9 set after signature commands when signature rejected.
// R11: Status bit 7 set after n check when order parameter invalid.
// R12: Status bit 6 set after couple check when x,y not below prime.
// R13: Status bit 5 set after any curve operation giving infinity.
// R14: Status bit 4 set after on-curve check when point is off curve.
// R15: Status bits 3:0 hold address of the last failing point.
// R16: Control bits 31:1 read as zero.
// R17: Status bits 31:17 read as zero.
// R18: Primitive group nibble 6 selects inversion for odd modulus.
// R19: Curve group nibbles 3,4,5,6 select AB, n, couple, on-curve checks.
// R20: Busy rises on the same edge that accepts a launch.
// R21: Result flags hold until their next updating command; reset zero. Here status bits 7:0 also change on a software status write.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pke_defs.svh"

module pke_launch_ctrl #(
  parameter int ADDR_W = 8
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  output logic                      eng_launch,
  output logic [31:0]               eng_command,
  output logic                      engine_busy,
  input  wire logic                 eng_done,
  input  wire logic                 res_prime_valid,
  input  wire logic                 res_composite,
  input  wire logic                 res_no_inverse,
  input  wire logic                 res_coeff_bad,
  input  wire logic                 res_sig_reject,
  input  wire logic                 res_order_bad,
  input  wire logic                 res_coord_bad,
  input  wire logic                 res_infinity,
  input  wire logic                 res_off_curve,
  input  wire pke_pkg::pke_fail_t   res_fail_addr
);

  pke_pkg::pke_state_e   state_r;
  pke_pkg::pke_state_e   state_nxt;
  pke_pkg::pke_opcode_t  run_op_r;
  logic                  launch_bit_r;
  logic                  busy_r;
  logic                  launch_pulse_r;
  logic [31:0]           command_r;
  logic [31:0]           rdata_r;
  logic [15:0]           flags;

  wire logic             sel_control;
  wire logic             sel_status;
  wire logic             sel_command;
  wire logic             wr_control;
  wire logic             wr_status;
  wire logic             wr_command;
  wire logic             launch_req;
  wire logic             accept;
  wire logic             finish;
  wire logic [31:0]      control_view;
  wire logic [31:0]      status_view;
  wire logic [31:0]      rd_mux;
  wire logic             upd_noinv;
  wire logic             upd_coeff;
  wire logic             upd_sig;
  wire logic             upd_order;
  wire logic             upd_coord;
  wire logic             upd_infty;
  wire logic             upd_offcrv;

  // Compare a bus address against one register offset
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  // Address decode
  assign sel_control = hit(reg_addr, `PKE_OFS_CONTROL);
  assign sel_status  = hit(reg_addr, `PKE_OFS_STATUS);
  assign sel_command = hit(reg_addr, `PKE_OFS_COMMAND);
  assign wr_control  = reg_wr & sel_control;
  assign wr_status   = reg_wr & sel_status;
  assign wr_command  = reg_wr & sel_command;

  // A launch is a write of one to bit 0; taken only when idle
  assign launch_req = wr_control & reg_wdata[`PKE_CTL_LAUNCH]; // [R2]
  assign accept     = launch_req & (state_r == pke_pkg::pke_idle); // [R4]
  // Completion only counts while an operation is in flight
  assign finish     = eng_done & (state_r == pke_pkg::pke_run);

  // Sequencer: idle until accepted, run until the datapath is done
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pke_pkg::pke_idle: begin
        if (accept) state_nxt = pke_pkg::pke_run; // [R3]
      end
      pke_pkg::pke_run: begin
        if (eng_done) state_nxt = pke_pkg::pke_idle;
      end
    endcase
  end

  // State, launch bit and busy move together so they never disagree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r      <= pke_pkg::pke_idle;
      launch_bit_r <= 1'b0;
      busy_r       <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (accept) begin
        launch_bit_r <= 1'b1; // [R2]
        busy_r       <= 1'b1; // [R20] [R6]
      end else if (finish) begin
        launch_bit_r <= 1'b0; // [R5]
        busy_r       <= 1'b0; // [R6]
      end
    end
  end

  // Opcode is frozen at launch so later command writes cannot
  // change which flags the finishing operation rewrites
  always_ff @(posedge clk) begin
    if (!rstn) begin
      run_op_r       <= 7'h00;
      launch_pulse_r <= 1'b0;
    end else begin
      launch_pulse_r <= accept; // [R3]
      if (accept) run_op_r <= command_r[6:0]; // [R3]
    end
  end

  // Command register; unimplemented bits never store
  always_ff @(posedge clk) begin
    if (!rstn) begin
      command_r <= `PKE_COMMAND_RST;
    end else if (wr_command) begin
      command_r <= reg_wdata & `PKE_COMMAND_MASK;
    end
  end

  // Map completion onto per-flag update enables
  pke_op_decode u_decode (
    .op         (run_op_r),
    .upd_noinv  (upd_noinv),
    .upd_coeff  (upd_coeff),
    .upd_sig    (upd_sig),
    .upd_order  (upd_order),
    .upd_coord  (upd_coord),
    .upd_infty  (upd_infty),
    .upd_offcrv (upd_offcrv)
  );

  // Result flags; a completing update beats a same-cycle software write
  pke_result_flags u_flags (
    .clk            (clk),
    .rstn           (rstn),
    .done           (finish),
    .upd_prime      (res_prime_valid), // [R7]
    .upd_noinv      (upd_noinv),
    .upd_coeff      (upd_coeff),
    .upd_sig        (upd_sig),
    .upd_order      (upd_order),
    .upd_coord      (upd_coord),
    .upd_infty      (upd_infty),
    .upd_offcrv     (upd_offcrv),
    .res_composite  (res_composite),
    .res_no_inverse (res_no_inverse),
    .res_coeff_bad  (res_coeff_bad),
    .res_sig_reject (res_sig_reject),
    .res_order_bad  (res_order_bad),
    .res_coord_bad  (res_coord_bad),
    .res_infinity   (res_infinity),
    .res_off_curve  (res_off_curve),
    .res_fail_addr  (res_fail_addr),
    .sw_wr          (wr_status),
    .sw_wdata       (reg_wdata[7:0]),
    .flags          (flags)
  );

  // Read views with unimplemented bits tied low
  assign control_view = {31'h0, launch_bit_r}; // [R16]
  assign status_view  = {15'h0, busy_r, flags}; // [R17] [R6]

  // Unmapped addresses read as zero
  assign rd_mux = sel_control ? control_view :
                  sel_status  ? status_view  :
                  sel_command ? command_r    : 32'h0000_0000;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata   = rdata_r;
  assign eng_launch  = launch_pulse_r;
  assign eng_command = command_r;
  assign engine_busy = busy_r;

endmodule // pke_launch_ctrl

`default_nettype wire

// file: sim/pke_launch_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "pke_defs.svh"

module pke_launch_props #(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire logic              eng_launch,
  input wire logic [31:0]       eng_command,
  input wire logic              engine_busy,
  input wire logic              eng_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Decoded bus events, named so each property reads as one relation
  wire go_wr  = reg_wr && reg_addr == ADDR_W'(`PKE_OFS_CONTROL) &&
                reg_wdata[`PKE_CTL_LAUNCH];
  wire ctl_rd = reg_rd && reg_addr == ADDR_W'(`PKE_OFS_CONTROL);
  wire st_rd  = reg_rd && reg_addr == ADDR_W'(`PKE_OFS_STATUS);
  wire cmd_wr = reg_wr && reg_addr == ADDR_W'(`PKE_OFS_COMMAND);

  a_launch_accept: assert property (go_wr && !engine_busy |=>
    engine_busy && eng_launch ##1 !eng_launch)
    else $error("accepted launch gave no busy or launch pulse");
  a_launch_ignored: assert property (engine_busy |=> !eng_launch)
    else $error("launch pulse while already busy");
  a_launch_cause: assert property (eng_launch |->
    $past(go_wr) && !$past(engine_busy))
    else $error("launch pulse without an accepted start write");
  a_busy_hold: assert property (engine_busy && !eng_done |=>
    engine_busy)
    else $error("busy dropped before completion");
  a_busy_drop: assert property (engine_busy && eng_done |=>
    !engine_busy && !eng_launch)
    else $error("busy still set after completion");
  a_busy_rise: assert property ($rose(engine_busy) |-> $past(go_wr))
    else $error("busy rose without a start write");
  a_ctrl_read: assert property (ctl_rd |=>
    reg_rdata == {31'h0000_0000, $past(engine_busy)})
    else $error("control read shows wrong start bit or upper bits");
  a_stat_read: assert property (st_rd |=>
    reg_rdata[31:16] == {15'h0000, $past(engine_busy)} &&
    reg_rdata[15:13] == 3'h0 && !reg_rdata[8])
    else $error("status read shows wrong busy or unused bits");
  a_cmd_capture: assert property (cmd_wr |=>
    eng_command == ($past(reg_wdata) & `PKE_COMMAND_MASK))
    else $error("command output does not follow command write");
endmodule // pke_launch_props

bind pke_launch_ctrl pke_launch_props #(.ADDR_W(ADDR_W)) pke_launch_props_i (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .eng_launch(eng_launch), .eng_command(eng_command),
  .engine_busy(engine_busy), .eng_done(eng_done)
);

`default_nettype wire

// file: sim/pke_engine_model.sv
`timescale 1ns/1ps
`default_nettype none

module pke_engine_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        eng_launch,
  input  wire logic [7:0]  lat,
  input  wire logic [12:0] res_val,
  input  wire logic        stray_done,
  output logic             eng_done,
  output logic [12:0]      res_bus
);
  logic [7:0] cnt_r;
  logic       run_r;
  logic       fire;

  // Datapath stand-in: counts lat cycles after a launch, then finishes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      run_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (eng_launch) begin
      run_r <= 1'b1;
      cnt_r <= lat;
    end else if (run_r && cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end else begin
      run_r <= 1'b0;
    end
  end

  // Results only hold in the done cycle; inverted otherwise to catch
  // a front end that samples them at the wrong moment
  assign fire     = run_r && cnt_r == 8'h00;
  assign eng_done = fire || stray_done;
  assign res_bus  = eng_done ? res_val : ~res_val;
endmodule // pke_engine_model

`default_nettype wire

// file: sim/test_pke_launch_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pke_defs.svh"

`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); \
  end \
end

module test_pke_launch_ctrl;
  logic        clk, rstn, reg_wr, reg_rd, eng_launch, engine_busy;
  logic        eng_done, stray;
  logic [7:0]  reg_addr, lat;
  logic [31:0] reg_wdata, reg_rdata;
  logic [12:0] res_val, res_bus;
  logic [15:0] exp_st;
  logic [6:0]  ops [14];
  int          fails, cmp_count, launches, cyc;

  pke_launch_ctrl pke_launch_ctrl_i (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .eng_launch(eng_launch), .eng_command(), .engine_busy(engine_busy),
    .eng_done(eng_done), .res_prime_valid(res_bus[12]),
    .res_composite(res_bus[11]), .res_no_inverse(res_bus[10]),
    .res_coeff_bad(res_bus[9]), .res_sig_reject(res_bus[8]),
    .res_order_bad(res_bus[7]), .res_coord_bad(res_bus[6]),
    .res_infinity(res_bus[5]), .res_off_curve(res_bus[4]),
    .res_fail_addr(res_bus[3:0])
  );

  pke_engine_model pke_engine_model_i (
    .clk(clk), .rstn(rstn), .eng_launch(eng_launch), .lat(lat),
    .res_val(res_val), .stray_done(stray), .eng_done(eng_done),
    .res_bus(res_bus)
  );

  // Clock, launch tally and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (eng_launch === 1'b1) launches++;
    cyc++;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test;
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask

  // Status bits that a finished opcode rewrites
  function automatic logic [15:0] own(input logic [6:0] op, input logic pv);
    logic [15:0] m;
    m = 16'h0000;
    m[12] = pv;
    m[11] = op == 7'h06 || op == 7'h09;
    m[10] = op == 7'h23;
    m[9] = op inside {7'h30, 7'h31, 7'h19, 7'h1a, 7'h2b};
    m[7] = op == 7'h24;
    m[6] = op == 7'h25;
    m[5] = op[6:5] == 2'h1;
    m[4] = op == 7'h26 || op == 7'h2c;
    return m;
  endfunction

  task automatic run_op(input logic [6:0] op, input logic r,
                        input logic slow);
    logic [15:0] m;
    logic [3:0]  fa;
    int          n;
    m = own(op, op == 7'h10);
    fa = op[3:0] ^ 4'ha;
    lat <= slow ? 8'h0c : 8'h03;
    res_val <= {op == 7'h10, {8{r}}, fa};
    wr(`PKE_OFS_COMMAND, {25'h0000000, op});
    wr(`PKE_OFS_CONTROL, 32'h0000_0001); // Operands already in place
    rd(`PKE_OFS_STATUS, {15'h0000, 1'b1, exp_st}, "busy");
    wr(`PKE_OFS_CONTROL, 32'h0000_0001);
    if (slow) begin
      wr(`PKE_OFS_CONTROL, 32'h0000_0000);
      rd(`PKE_OFS_CONTROL, 32'h0000_0001, "start held");
    end
    n = 0;
    while (engine_busy !== 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    exp_st = (exp_st & ~m) | (r ? m : 16'h0000);
    if (r && (m[6] || m[5] || m[4])) exp_st[3:0] = fa;
    rd(`PKE_OFS_CONTROL, 32'h0000_0000, "start cleared");
    rd(`PKE_OFS_STATUS, {16'h0000, exp_st}, "flags");
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {reg_wr, reg_rd, stray, reg_addr, reg_wdata} = '0;
    {lat, res_val, exp_st} = '0;
    ops = '{7'h06, 7'h09, 7'h10, 7'h23, 7'h24, 7'h25, 7'h26, 7'h2c,
            7'h30, 7'h31, 7'h19, 7'h1a, 7'h2b, 7'h20};
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(`PKE_OFS_CONTROL, 32'h0000_0000, "control reset");
    rd(`PKE_OFS_STATUS, 32'h0000_0000, "status reset");
    wr(`PKE_OFS_COMMAND, 32'hffff_ffff);
    rd(`PKE_OFS_COMMAND, `PKE_COMMAND_MASK, "command mask");
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, 32'h0000_0000, "unmapped");
    wr(`PKE_OFS_STATUS, 32'hffff_ffff);
    rd(`PKE_OFS_STATUS, 32'h0000_00ff, "status writable");
    wr(`PKE_OFS_STATUS, 32'h0000_0000);
    // Pass one sets every owned flag, pass two clears only owned ones
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 14; i++)
        run_op(ops[i], p == 0, i[0]);
    // A completion while idle must leave the flags alone
    res_val <= 13'h1fff;
    stray <= 1'b1;
    @(posedge clk);
    stray <= 1'b0;
    rd(`PKE_OFS_STATUS, {16'h0000, exp_st}, "idle done");
    `CHK("launch count", 28, launches)
    // Completion and a status write in one cycle: owned bits take the
    // result, the others keep what software wrote
    lat <= 8'h02;
    res_val <= {1'b0, 8'hff, 4'h5};
    wr(`PKE_OFS_COMMAND, 32'h0000_0024);
    wr(`PKE_OFS_CONTROL, 32'h0000_0001);
    wr(`PKE_OFS_STATUS, 32'h0000_0050);
    wr(`PKE_OFS_STATUS, 32'h0000_0000); // Lands on the done edge
    exp_st[7:0] = 8'ha5; // Order bad, infinity, location 5
    rd(`PKE_OFS_STATUS, {16'h0000, exp_st}, "write vs done");
    finish_test();
  end
endmodule // test_pke_launch_ctrl

`default_nettype wire
